// *** verilog/ces_pkg.sv ***
package ces_pkg;
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  localparam logic [23:0] NMI_ACK_ADDR = 24'hFF_FF00;
  localparam logic [23:0] INT_ACK_ADDR = 24'hFF_FE00;
  localparam logic [23:0] PBASE_OFS = 24'h00_0008;
  localparam logic [23:0] STEP_HALF = 24'h00_0002;
  localparam logic [23:0] STEP_WORD = 24'h00_0004;
  localparam logic [3:0] ST_ACK_MAST = 4'h4;
  localparam logic [3:0] ST_ACK_CASC = 4'h5;
  localparam logic [3:0] ST_FETCH = 4'h8;
  localparam logic [3:0] ST_MEM_RD = 4'hA;
  localparam logic [3:0] ST_MEM_WR = 4'hB;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // ----------------------------------------
  // Vectors and flags
  // ----------------------------------------
  localparam logic [7:0] VEC_NVI = 8'h00;
  localparam logic [7:0] VEC_NMI = 8'h01;
  localparam logic [7:0] VEC_TRC = 8'h09;
  localparam logic [7:0] CASC_LOW = 8'hF0;
  localparam int F_T = 1;
  localparam int F_U = 8;
  localparam int F_S = 9;
  localparam int F_P = 10;
  localparam int F_I = 11;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  typedef enum logic [2:0] {
    TK_SLAVE = 3'h0, TK_PRIV = 3'h1, TK_SVC = 3'h2, TK_DVZ = 3'h3,
    TK_FLG = 3'h4, TK_BPT = 3'h5, TK_UND = 3'h6
  } ces_trap_e;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RO_CFG = 8'h00;
  localparam logic [7:0] RO_FLAGS = 8'h04;
  localparam logic [7:0] RO_BASE = 8'h08;
  localparam logic [7:0] RO_ISP = 8'h0C;
  localparam logic [7:0] RO_PC = 8'h10;
  localparam logic [7:0] RO_SB = 8'h14;
  localparam logic [7:0] RO_LINK = 8'h18;
  localparam logic [7:0] RO_STAT = 8'h1C;
  typedef struct packed {
    logic [23:0] addr;
    logic [3:0] status;
    logic wr;
    logic [1:0] size;
    logic [31:0] wdata;
  } ces_cyc_s;
  typedef struct packed {
    logic [23:0] first;
    logic [23:0] next;
    logic [15:0] pre_flags;
    logic [23:0] pre_sp;
    logic str_open;
  } ces_core_s;
  function automatic logic [7:0] trap_vec(input ces_trap_e k);
    unique case (k)
      TK_SLAVE: trap_vec = 8'h03;
      TK_PRIV: trap_vec = 8'h04;
      TK_SVC: trap_vec = 8'h05;
      TK_DVZ: trap_vec = 8'h06;
      TK_FLG: trap_vec = 8'h07;
      TK_BPT: trap_vec = 8'h08;
      default: trap_vec = 8'h0A;
    endcase
  endfunction
endpackage

// *** verilog/ces_req_catch.sv ***
`timescale 1ns/1ps
module ces_req_catch (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins
  input wire logic nmi_n,
  input wire logic irq_n,
  // Sequencer side
  input wire logic nmi_taken,
  output logic nmi_pend,
  output logic irq_lvl
);
  logic [2:0] nmi_sh_q;
  logic [1:0] irq_sh_q;
  logic fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_sh_q <= 3'h7;
      irq_sh_q <= 2'h3;
    end else begin
      nmi_sh_q <= {nmi_sh_q[1:0], nmi_n};
      irq_sh_q <= {irq_sh_q[0], irq_n};
    end
  end

  // Edge seen only past the second stage
  assign fall = nmi_sh_q[2] & ~nmi_sh_q[1];

  // A new edge in the taking cycle stays pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_pend <= 1'b0;
    end else begin
      nmi_pend <= fall | (nmi_pend & ~nmi_taken);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_lvl <= 1'b0;
    end else begin
      irq_lvl <= ~irq_sh_q[1];
    end
  end
endmodule // ces_req_catch

// *** verilog/ces_bus_port.sv ***
`timescale 1ns/1ps
module ces_bus_port (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer side
  input wire logic go,
  input wire ces_pkg::ces_cyc_s cyc,
  output logic done,
  output logic [31:0] rdata,
  // Memory side
  output logic mem_req,
  output ces_pkg::ces_cyc_s mem_cyc,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import ces_pkg::*;

  // One cycle at a time, so nothing overlaps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= 1'b0;
      mem_cyc <= '0;
    end else if (go) begin
      mem_req <= 1'b1;
      mem_cyc <= cyc;
    end else if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= mem_req & mem_ack;
      if (mem_req && mem_ack) begin
        rdata <= mem_rdata;
      end
    end
  end
endmodule // ces_bus_port

// *** verilog/ces_seq.sv ***
// How it works
// - NMI falling edge: byte ack read at FFFF00, code 0100, vector 1
// - NMI return uses trap return, with no special bus cycle
// - Non-trace traps push the trapped instruction's first-byte address
// - Trap entry leaves the interrupt-enable flag as it was
// - Eight traps: slave, privilege, call, divide, flag, break, trace, opcode
// - At a boundary interrupts go first, NMI before maskable
// - No interrupt and trace-pending set: trace trap; else start instruction
// - Inside an instruction: interrupt if interruptible, plus one of seven traps
// - Interrupts start at boundaries or interruptible points of long instructions
// - Unfinished string: clear trace-pending, return to its first byte
// - Interrupt saves flags, clears stack, user, trace, pending, enable
// - Non-vectored: byte ack read at FFFE00, code 0100, vector 0
// - Vectored: controller byte from FFFE00, non-negative is the vector
// - Byte -16..-1: cascade address at base+4*byte, then read vector, 0101
// - Other traps restore sp and flags, save, clear, vectors 3-8 and 10
// - Trace: clear pending, save, clear stack, user, trace, vector 9
// - Service pushes saved flags as 16 bits, reads descriptor at base+4*vec
// - Link from descriptor; pc is program base at link+8 plus offset
// - Flush and fetch handler, push link 16, return 32, commit link
// - Config bit selects non-vectored (0) or vectored (1) maskable input
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module ces_seq (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic nmi_n,
  input wire logic irq_n,
  // Core
  input wire logic core_bnd,
  input wire logic core_ipt,
  input wire logic core_trap,
  input wire ces_pkg::ces_trap_e core_kind,
  input wire logic core_trap_return_instr,
  input wire ces_pkg::ces_core_s core_info,
  output logic core_go,
  output logic core_redirect,
  output logic [23:0] core_pc,
  // Memory
  output logic mem_req,
  output ces_pkg::ces_cyc_s mem_cyc,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import ces_pkg::*;

  typedef enum logic [10:0] {
    S_IDLE = 11'h001, S_ACK = 11'h002, S_CADR = 11'h004, S_CVEC = 11'h008,
    S_PSHF = 11'h010, S_DESC = 11'h020, S_PBAS = 11'h040, S_SBAS = 11'h080,
    S_FTCH = 11'h100, S_PSHL = 11'h200, S_PSHR = 11'h400
  } ces_st_e;

  function automatic logic [23:0] tab_addr(input logic [23:0] b, input logic [7:0] i,
                                           input logic sx);
    tab_addr = b + {{14{sx & i[7]}}, i, 2'b00};
  endfunction

  function automatic logic [23:0] push_at(input logic [23:0] sp, input logic [1:0] sz);
    push_at = sp - ((sz == SZ_WORD) ? STEP_WORD : STEP_HALF);
  endfunction

  ces_st_e st_q;
  logic [15:0] flags_q;
  logic [15:0] saved_q;
  logic [15:0] link_q;
  logic [15:0] tlink_q;
  logic [23:0] base_q;
  logic [23:0] isp_q;
  logic [23:0] sb_q;
  logic [23:0] ret_q;
  logic [23:0] casc_q;
  logic [31:0] desc_q;
  logic [7:0] vec_q;
  logic cfg_vec_q;
  logic is_nmi_q;
  logic nmi_act_q;
  logic issued_q;
  logic nmi_pend;
  logic irq_lvl;
  logic bus_done;
  logic [31:0] bus_rdata;
  logic mem_go;
  ces_cyc_s cyc_d;
  logic idle;
  logic irq_ok;
  logic take_nmi;
  logic take_int;
  logic take_trc;
  logic take_trap;
  logic start_go;
  logic [15:0] trap_fl;
  logic [15:0] int_fl;
  logic [7:0] byte_in;

  // ----------------------------------------
  // Requests and memory port
  // ----------------------------------------
  ces_req_catch u_catch (
    .hclk(hclk),
    .hresetn(hresetn),
    .nmi_n(nmi_n),
    .irq_n(irq_n),
    .nmi_taken(take_nmi),
    .nmi_pend(nmi_pend),
    .irq_lvl(irq_lvl)
  );

  ces_bus_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(mem_go),
    .cyc(cyc_d),
    .done(bus_done),
    .rdata(bus_rdata),
    .mem_req(mem_req),
    .mem_cyc(mem_cyc),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ----------------------------------------
  // Decision at boundaries
  // ----------------------------------------
  assign idle = (st_q == S_IDLE);
  assign irq_ok = irq_lvl & flags_q[F_I];
  assign take_trap = idle & core_trap;
  assign take_nmi = idle & ~core_trap & (core_bnd | core_ipt) & nmi_pend;
  assign take_int = idle & ~core_trap & (core_bnd | core_ipt) & ~nmi_pend & irq_ok;
  assign take_trc = idle & ~core_trap & core_bnd & ~nmi_pend & ~irq_ok & flags_q[F_P];
  assign start_go = idle & ~core_trap & core_bnd & ~nmi_pend & ~irq_ok & ~flags_q[F_P];
  assign mem_go = ~idle & ~issued_q;
  assign byte_in = bus_rdata[7:0];

  always_comb begin
    int_fl = flags_q;
    if (core_ipt && core_info.str_open) begin
      int_fl[F_P] = 1'b0;
    end
    trap_fl = core_info.pre_flags;
    if (core_kind == TK_UND) begin
      trap_fl[F_P] = 1'b0;
    end
  end

  // ----------------------------------------
  // Bus cycle of each step
  // ----------------------------------------
  always_comb begin
    cyc_d = '0;
    cyc_d.status = ST_MEM_RD;
    cyc_d.size = SZ_WORD;
    unique case (st_q)
      S_ACK: begin
        cyc_d.addr = is_nmi_q ? NMI_ACK_ADDR : INT_ACK_ADDR;
        cyc_d.status = ST_ACK_MAST;
        cyc_d.size = SZ_BYTE;
      end
      S_CADR: cyc_d.addr = tab_addr(base_q, vec_q, 1'b1);
      S_CVEC: begin
        cyc_d.addr = casc_q;
        cyc_d.status = ST_ACK_CASC;
        cyc_d.size = SZ_BYTE;
      end
      S_PSHF, S_PSHL: begin
        cyc_d.addr = push_at(isp_q, SZ_HALF);
        cyc_d.status = ST_MEM_WR;
        cyc_d.wr = 1'b1;
        cyc_d.size = SZ_HALF;
        cyc_d.wdata = {16'h0000, (st_q == S_PSHF) ? saved_q : link_q};
      end
      S_DESC: cyc_d.addr = tab_addr(base_q, vec_q, 1'b0);
      S_PBAS: cyc_d.addr = {8'h00, tlink_q} + PBASE_OFS;
      S_SBAS: cyc_d.addr = {8'h00, tlink_q};
      S_FTCH: begin
        cyc_d.addr = core_pc;
        cyc_d.status = ST_FETCH;
        cyc_d.size = SZ_HALF;
      end
      S_PSHR: begin
        cyc_d.addr = push_at(isp_q, SZ_WORD);
        cyc_d.status = ST_MEM_WR;
        cyc_d.wr = 1'b1;
        cyc_d.wdata = {8'h00, ret_q};
      end
      default: cyc_d.size = SZ_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      issued_q <= 1'b0;
    end else if (bus_done) begin
      issued_q <= 1'b0;
    end else if (mem_go) begin
      issued_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
    end else if (take_nmi || take_int) begin
      st_q <= S_ACK;
    end else if (take_trap || take_trc) begin
      st_q <= S_PSHF;
    end else if (bus_done) begin
      unique case (st_q)
        S_ACK: begin
          if (!is_nmi_q && cfg_vec_q && byte_in >= CASC_LOW) begin
            st_q <= S_CADR;
          end else begin
            st_q <= S_PSHF;
          end
        end
        S_CADR: st_q <= S_CVEC;
        S_CVEC: st_q <= S_PSHF;
        S_PSHF: st_q <= S_DESC;
        S_DESC: st_q <= S_PBAS;
        S_PBAS: st_q <= S_SBAS;
        S_SBAS: st_q <= S_FTCH;
        S_FTCH: st_q <= S_PSHL;
        S_PSHL: st_q <= S_PSHR;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_q <= VEC_NVI;
      is_nmi_q <= 1'b0;
    end else if (take_nmi || take_int) begin
      is_nmi_q <= take_nmi;
    end else if (take_trap) begin
      vec_q <= trap_vec(core_kind);
    end else if (take_trc) begin
      vec_q <= VEC_TRC;
    end else if (bus_done && st_q == S_ACK) begin
      if (is_nmi_q) begin
        vec_q <= VEC_NMI;
      end else if (!cfg_vec_q) begin
        vec_q <= VEC_NVI;
      end else begin
        vec_q <= byte_in;
      end
    end else if (bus_done && st_q == S_CVEC) begin
      vec_q <= byte_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_q <= '0;
      saved_q <= '0;
    end else if (take_nmi || take_int) begin
      ret_q <= (core_ipt && core_info.str_open) ? core_info.first : core_info.next;
      saved_q <= int_fl;
    end else if (take_trap) begin
      ret_q <= core_info.first;
      saved_q <= trap_fl;
    end else if (take_trc) begin
      ret_q <= core_info.next;
      saved_q <= flags_q & ~(16'h0001 << F_P);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      casc_q <= '0;
      desc_q <= '0;
      tlink_q <= '0;
      core_pc <= '0;
      sb_q <= '0;
    end else if (bus_done) begin
      unique case (st_q)
        S_CADR: casc_q <= bus_rdata[23:0];
        S_DESC: begin
          desc_q <= bus_rdata;
          tlink_q <= bus_rdata[15:0];
        end
        S_PBAS: core_pc <= bus_rdata[23:0] + {8'h00, desc_q[31:16]};
        S_SBAS: sb_q <= bus_rdata[23:0];
        default: sb_q <= sb_q;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_go <= 1'b0;
      core_redirect <= 1'b0;
    end else begin
      core_go <= start_go;
      core_redirect <= bus_done & (st_q == S_PSHR);
    end
  end

  // Return through the trap-return path needs no bus cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_act_q <= 1'b0;
    end else if (take_nmi) begin
      nmi_act_q <= 1'b1;
    end else if (core_trap_return_instr) begin
      nmi_act_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // AHB-Lite registers
  // ----------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;
  logic ap_ok;
  logic [31:0] rd_mux;

  assign ap_ok = hsel & hready & htrans[1];

  always_comb begin
    unique case (haddr[7:0])
      RO_CFG: rd_mux = {31'h0000_0000, cfg_vec_q};
      RO_FLAGS: rd_mux = {16'h0000, flags_q};
      RO_BASE: rd_mux = {8'h00, base_q};
      RO_ISP: rd_mux = {8'h00, isp_q};
      RO_PC: rd_mux = {8'h00, core_pc};
      RO_SB: rd_mux = {8'h00, sb_q};
      RO_LINK: rd_mux = {16'h0000, link_q};
      RO_STAT: rd_mux = {22'h00_0000, nmi_act_q, ~idle, vec_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
      wr_pend_q <= 1'b0;
      wr_ofs_q <= '0;
    end else begin
      wr_pend_q <= ap_ok & hwrite;
      wr_ofs_q <= haddr[7:0];
      if (ap_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_vec_q <= 1'b0;
      base_q <= '0;
    end else if (wr_pend_q) begin
      if (wr_ofs_q == RO_CFG) begin
        cfg_vec_q <= hwdata[0];
      end
      if (wr_ofs_q == RO_BASE) begin
        base_q <= hwdata[23:0];
      end
    end
  end

  localparam logic [15:0] CLR_TUSP = (16'h0001 << F_S) | (16'h0001 << F_U)
    | (16'h0001 << F_T) | (16'h0001 << F_P);

  // Sequence updates win over software writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= FLAGS_RST;
    end else if (take_nmi || take_int) begin
      flags_q <= int_fl & ~(CLR_TUSP | (16'h0001 << F_I));
    end else if (take_trap) begin
      flags_q <= trap_fl & ~CLR_TUSP;
    end else if (take_trc) begin
      flags_q <= flags_q & ~CLR_TUSP;
    end else if (start_go) begin
      flags_q[F_P] <= flags_q[F_T];
    end else if (wr_pend_q && wr_ofs_q == RO_FLAGS) begin
      flags_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isp_q <= '0;
    end else if (take_trap) begin
      isp_q <= core_info.pre_sp;
    end else if (bus_done && (st_q == S_PSHF || st_q == S_PSHL)) begin
      isp_q <= push_at(isp_q, SZ_HALF);
    end else if (bus_done && st_q == S_PSHR) begin
      isp_q <= push_at(isp_q, SZ_WORD);
    end else if (idle && wr_pend_q && wr_ofs_q == RO_ISP) begin
      isp_q <= hwdata[23:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_q <= '0;
    end else if (bus_done && st_q == S_PSHR) begin
      link_q <= tlink_q;
    end else if (idle && wr_pend_q && wr_ofs_q == RO_LINK) begin
      link_q <= hwdata[15:0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_nmi_ack_cycle: assert property (
    mem_go && st_q == S_ACK && is_nmi_q |=> mem_cyc.addr == NMI_ACK_ADDR
      && mem_cyc.status == ST_ACK_MAST && mem_req)
    else $error("nmi ack cycle wrong");
  chk_nmi_vector: assert property (
    bus_done && st_q == S_ACK && is_nmi_q |=> vec_q == VEC_NMI && st_q == S_PSHF)
    else $error("nmi vector not 1");
  chk_trap_return_instr_quiet: assert property (
    core_trap_return_instr && idle && !core_trap && !core_bnd && !core_ipt |=> !mem_go)
    else $error("bus cycle on trap return");
  chk_trap_return: assert property (
    take_trap |=> ret_q == $past(core_info.first) && st_q == S_PSHF)
    else $error("trap return address wrong");
  chk_trap_ien: assert property (
    take_trap |=> flags_q[F_I] == $past(core_info.pre_flags[F_I]))
    else $error("trap touched enable flag");
  chk_nmi_first: assert property (
    idle && core_bnd && !core_trap && nmi_pend |=> st_q == S_ACK && is_nmi_q)
    else $error("nmi not served first");
  chk_trace_take: assert property (
    take_trc |=> vec_q == VEC_TRC ##1 !flags_q[F_P])
    else $error("trace trap not taken");
  chk_int_clear: assert property (
    take_int |=> !flags_q[F_I] && !flags_q[F_S] && !flags_q[F_U] && !flags_q[F_T])
    else $error("interrupt flags not cleared");
  chk_casc_status: assert property (
    mem_go && st_q == S_CVEC |=> mem_cyc.status == ST_ACK_CASC)
    else $error("cascade status wrong");
  chk_push_order: assert property (
    bus_done && st_q == S_PSHF |=> st_q == S_DESC ##[1:1000] st_q == S_PBAS)
    else $error("flags push not followed by descriptor");
  chk_one_cycle: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_cyc))
    else $error("bus cycle dropped or changed");

  cov_nmi: cover property (take_nmi ##[1:300] core_redirect);
  cov_cascade: cover property (st_q == S_CADR ##[1:300] st_q == S_CVEC);
  cov_trap: cover property (take_trap ##[1:300] core_redirect);
endmodule // ces_seq

// *** test/ces_mem_model.sv ***
`timescale 1ns/1ps
module ces_mem_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Memory side
  input wire logic mem_req,
  input wire ces_pkg::ces_cyc_s mem_cyc,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Control
  input wire logic [1:0] dly,
  input wire logic [7:0] ack_byte,
  input wire logic [7:0] casc_byte
);
  import ces_pkg::*;
  logic [1:0] wait_q;
  logic [31:0] last_q;
  logic [31:0] val;
  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  // Delay is re-drawn every cycle, so prompt and slow answers both occur
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 2'h0;
      last_q <= 32'h0000_0000;
    end else if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
    end else begin
      wait_q <= 2'h0;
      if (mem_ack) begin
        last_q <= val;
      end
    end
  end
  assign mem_ack = mem_req && (wait_q >= dly);
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    if (mem_cyc.status == ST_ACK_MAST) begin
      val = {24'h00_0000, ack_byte};
    end else if (mem_cyc.status == ST_ACK_CASC) begin
      val = {24'h00_0000, casc_byte};
    end else begin
      val = {8'h00, mem_cyc.addr} * 32'h0000_0003;
    end
  end
  // Released bus never repeats the last word
  assign mem_rdata = mem_ack ? val : ~last_q;
endmodule // ces_mem_model

// *** test/cpu_exception_sequencer_tb.sv ***
`timescale 1ns/1ps
module cpu_exception_sequencer_tb;
  import ces_pkg::*;
  logic hclk, hresetn, hwrite, hreadyout, hresp, nmi_n, irq_n, g;
  logic core_bnd, core_ipt, core_trap, core_trap_return_instr, core_go, core_redirect, mem_req, mem_ack;
  logic [1:0] htrans, dly;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata, rd, m, t;
  logic [23:0] core_pc, lk_m;
  logic [15:0] fl;
  logic [7:0] ack_byte, casc_byte;
  ces_trap_e core_kind;
  ces_core_s core_info;
  ces_cyc_s mem_cyc, e;
  ces_cyc_s exp_q[$];
  int fail_count, cmp_count, r, q, seed = 65859;
  int vt[7] = '{3, 4, 5, 6, 7, 8, 10};
  localparam logic [23:0] BASE = 24'h00_1000;
  localparam logic [23:0] SP = 24'h00_0800;
  localparam logic [23:0] FIRST = 24'h00_2FF0;
  localparam logic [23:0] NEXT = 24'h00_3000;
  ces_seq u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .nmi_n(nmi_n), .irq_n(irq_n), .core_bnd(core_bnd),
    .core_ipt(core_ipt), .core_trap(core_trap), .core_kind(core_kind), .core_trap_return_instr(core_trap_return_instr),
    .core_info(core_info), .core_go(core_go), .core_redirect(core_redirect), .core_pc(core_pc),
    .mem_req(mem_req), .mem_cyc(mem_cyc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ces_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_cyc(mem_cyc),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dly(dly), .ack_byte(ack_byte),
    .casc_byte(casc_byte));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [31:0] mval(input logic [23:0] a);
    mval = {8'h00, a} * 32'h0000_0003;
  endfunction
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 9);
    if (n >= 9) begin
      chk(1'b0, "hready timeout");
      tally_and_finish;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    rd = hrdata;
  endtask
  task automatic ex(input logic [23:0] a, input logic [3:0] s, input logic [1:0] z,
      input logic [31:0] d);
    exp_q.push_back({a, s, s == ST_MEM_WR, z, d});
  endtask
  task automatic go_seq(input int sel, input logic [7:0] v, input logic [23:0] ret,
      input logic [15:0] sv, input logic [15:0] af, input logic gox);
    logic [31:0] d, pb;
    logic [23:0] lk;
    int n;
    d = mval(BASE + {14'h0000, v, 2'h0});
    lk = {8'h00, d[15:0]};
    pb = mval(lk + PBASE_OFS);
    if (!gox) begin
      ex(SP - STEP_HALF, ST_MEM_WR, SZ_HALF, {16'h0000, sv});
      ex(BASE + {14'h0000, v, 2'h0}, ST_MEM_RD, SZ_WORD, 32'h0);
      ex(lk + PBASE_OFS, ST_MEM_RD, SZ_WORD, 32'h0);
      ex(lk, ST_MEM_RD, SZ_WORD, 32'h0);
      ex(pb[23:0] + {8'h00, d[31:16]}, ST_FETCH, SZ_HALF, 32'h0);
      ex(SP - STEP_WORD, ST_MEM_WR, SZ_HALF, {16'h0000, lk_m[15:0]});
      ex(SP - 24'h00_0008, ST_MEM_WR, SZ_WORD, {8'h00, ret});
    end
    ahb(1'b1, RO_ISP, {8'h00, SP});
    if (sel == 0) core_bnd <= 1'b1;
    else if (sel == 1) core_ipt <= 1'b1;
    else core_trap <= 1'b1;
    @(posedge hclk);
    {core_bnd, core_ipt, core_trap} <= 3'b000;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (core_go !== 1'b1 && core_redirect !== 1'b1 && n < 300);
    g = core_go;
    @(posedge hclk);
    if (n >= 300) begin
      chk(1'b0, "no answer from sequencer");
      tally_and_finish;
    end
    chk(g === gox && exp_q.size() == 0, "outcome or cycle count");
    if (!gox) begin
      lk_m = lk;
      ahb(1'b0, RO_FLAGS, 32'h0);
      chk(rd[15:0] === af, "flags after entry");
      ahb(1'b0, RO_STAT, 32'h0);
      chk(rd[7:0] === v, "vector");
    end
    $display("seq %0d vec %0h done", sel, v);
  endtask
  // ----------------------------------------
  // Memory cycle monitor
  // ----------------------------------------
  always @(posedge hclk) begin
    q = $random(seed);
    dly <= q[1:0];
    if (hresetn && mem_req && mem_ack) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      m = (e.size == SZ_WORD) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      m = e.wr ? m : 32'h0000_0000;
      chk(mem_cyc.addr === e.addr && mem_cyc.status === e.status && mem_cyc.wr === e.wr
        && mem_cyc.size === e.size && (mem_cyc.wdata & m) === (e.wdata & m),
        "bus cycle");
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hwrite, core_bnd, core_ipt, core_trap, core_trap_return_instr} = '0;
    {htrans, haddr, hwdata} = '0;
    {nmi_n, irq_n} = 2'b11;
    ack_byte = 8'h5A;
    casc_byte = 8'hC3;
    core_kind = TK_SLAVE;
    core_info = '{FIRST, NEXT, 16'h0000, SP, 1'b0};
    fail_count = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, RO_STAT, 32'h0);
    chk(rd === 32'h0000_0000, "status after reset");
    ahb(1'b0, 8'hFC, 32'h0);
    chk(rd === 32'h0000_0000, "unmapped read");
    ahb(1'b1, RO_BASE, {8'h00, BASE});
    ahb(1'b1, RO_LINK, 32'h0000_1234);
    lk_m = 24'h00_1234;
    go_seq(0, 8'h00, NEXT, 16'h0000, 16'h0000, 1'b1);
    ahb(1'b1, RO_FLAGS, 32'h0000_0802);
    go_seq(0, 8'h00, NEXT, 16'h0000, 16'h0000, 1'b1);
    go_seq(0, VEC_TRC, NEXT, 16'h0802, 16'h0800, 1'b0);
    for (int k = 0; k < 7; k++) begin
      r = $random(seed);
      core_kind <= ces_trap_e'(k);
      core_info.pre_flags <= r[15:0];
      fl = (k == 6) ? (r[15:0] & 16'hFBFF) : r[15:0];
      go_seq(2, vt[k][7:0], FIRST, fl, fl & 16'hF8FD, 1'b0);
    end
    ahb(1'b1, RO_FLAGS, 32'h0000_0800);
    {nmi_n, irq_n} <= 2'b00;
    repeat (4) @(posedge hclk);
    ex(NMI_ACK_ADDR, ST_ACK_MAST, SZ_BYTE, 32'h0);
    go_seq(0, VEC_NMI, NEXT, 16'h0800, 16'h0000, 1'b0);
    nmi_n <= 1'b1;
    go_seq(0, 8'h00, NEXT, 16'h0000, 16'h0000, 1'b1);
    core_trap_return_instr <= 1'b1;
    @(posedge hclk);
    core_trap_return_instr <= 1'b0;
    repeat (20) @(posedge hclk);
    ahb(1'b0, RO_STAT, 32'h0);
    chk(rd[9:8] === 2'b00 && exp_q.size() == 0, "trap return");
    ahb(1'b1, RO_FLAGS, 32'h0000_0C02);
    core_info.str_open <= 1'b1;
    ex(INT_ACK_ADDR, ST_ACK_MAST, SZ_BYTE, 32'h0);
    go_seq(1, VEC_NVI, FIRST, 16'h0802, 16'h0000, 1'b0);
    core_info.str_open <= 1'b0;
    ahb(1'b1, RO_CFG, 32'h0000_0001);
    ahb(1'b1, RO_FLAGS, 32'h0000_0800);
    ack_byte <= 8'h25;
    ex(INT_ACK_ADDR, ST_ACK_MAST, SZ_BYTE, 32'h0);
    go_seq(0, 8'h25, NEXT, 16'h0800, 16'h0000, 1'b0);
    ahb(1'b1, RO_FLAGS, 32'h0000_0800);
    ack_byte <= 8'hFE;
    t = mval(BASE - 24'h00_0008);
    ex(INT_ACK_ADDR, ST_ACK_MAST, SZ_BYTE, 32'h0);
    ex(BASE - 24'h00_0008, ST_MEM_RD, SZ_WORD, 32'h0);
    ex(t[23:0], ST_ACK_CASC, SZ_BYTE, 32'h0);
    go_seq(0, 8'hC3, NEXT, 16'h0800, 16'h0000, 1'b0);
    irq_n <= 1'b1;
    tally_and_finish;
  end
endmodule // cpu_exception_sequencer_tb
